// >>> hw/link_err_pkg.sv
// shared constants and types for the link error reporter
package link_err_pkg;

	////////////////////////////////////////////////////////////////////////
	// register map, byte addresses on the register port
	localparam int ADDR_W = 8;
	localparam logic [7:0] REG_ERR_STATUS = 8'h00;
	localparam logic [7:0] REG_IRQ_MASK = 8'h04;
	localparam logic [7:0] REG_SEVERITY = 8'h08;
	localparam logic [7:0] REG_MSG_MASK = 8'h0c;
	localparam logic [7:0] REG_CONTROL = 8'h10;
	localparam logic [7:0] REG_DEV_STATUS = 8'h14;

	////////////////////////////////////////////////////////////////////////
	// error status layout, shared by status, irq mask, severity, msg mask
	localparam int NUM_ERR = 7;
	localparam int NUM_UNC = 3;
	localparam int ERR_RX_OVERFLOW = 0;
	localparam int ERR_FC_PROTOCOL = 1;
	localparam int ERR_LINK_PROTOCOL = 2;
	localparam int ERR_BAD_TLP = 3;
	localparam int ERR_BAD_DLLP = 4;
	localparam int ERR_REPLAY_ROLLOVER = 5;
	localparam int ERR_REPLAY_TIMEOUT = 6;

	// control register bits
	localparam int CTL_COR_REPORT_EN = 0;
	localparam int CTL_NONFATAL_REPORT_EN = 1;
	localparam int CTL_FATAL_REPORT_EN = 2;
	localparam int CTL_SYSTEM_ERROR_EN = 3;
	localparam int CTL_W = 4;

	// device status bits
	localparam int DEV_COR_DETECTED = 0;
	localparam int DEV_NONFATAL_DETECTED = 1;
	localparam int DEV_FATAL_DETECTED = 2;
	localparam int DEV_SIGNALLED_SERR = 3;
	localparam int DEV_W = 4;

	// reset values
	localparam logic [6:0] ERR_RESET = 7'h00;
	localparam logic [6:0] IRQ_MASK_RESET = 7'h00;
	localparam logic [6:0] SEVERITY_RESET = 7'h01;
	localparam logic [6:0] MSG_MASK_RESET = 7'h00;
	localparam logic [3:0] CONTROL_RESET = 4'h0;
	localparam logic [3:0] DEV_RESET = 4'h0;

	////////////////////////////////////////////////////////////////////////
	// flow control credit limits
	localparam int HDR_W = 8;
	localparam int DATA_W = 12;
	localparam int SEQ_W = 12;
	localparam logic [7:0] HDR_MAX = 8'h7f;
	localparam logic [11:0] DATA_MAX = 12'h7ff;
	localparam logic [7:0] HDR_INIT_MIN = 8'h01;
	// smallest non-infinite data credit a partner may first advertise, plain default
	localparam logic [11:0] DATA_INIT_MIN = 12'h008;
	localparam logic [7:0] HDR_INFINITE = 8'h00;
	localparam logic [11:0] DATA_INFINITE = 12'h000;
	localparam int FC_TYPES = 4;

	////////////////////////////////////////////////////////////////////////
	// types
	typedef enum logic [1:0] {MSG_COR, MSG_NONFATAL, MSG_FATAL} msg_kind_t;

	typedef struct packed {
		logic valid;
		msg_kind_t kind;
	} msg_t;

	typedef struct packed {
		logic valid;
		logic [1:0] fc_type;
		logic [HDR_W-1:0] hdr;
		logic [DATA_W-1:0] data;
	} fc_adv_t;

endpackage

// >>> hw/fc_credit_check.sv
// flow control credit checker, one registered error pulse per cycle with a bad init or update advertisement
module fc_credit_check (
	// clock and reset
	input wire logic mclk,
	input wire logic arst_n,
	// credit advertisements from the partner
	input wire link_err_pkg::fc_adv_t fc_init,
	input wire link_err_pkg::fc_adv_t fc_update,
	// result
	output logic fc_err_q
);

	logic [link_err_pkg::FC_TYPES-1:0] inf_hdr_q;
	logic [link_err_pkg::FC_TYPES-1:0] inf_data_q;
	logic init_bad;
	logic update_bad;

	////////////////////////////////////////////////////////////////////////
	// remember which types were first advertised as infinite
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			inf_hdr_q <= '0;
			inf_data_q <= '0;
		end else if (fc_init.valid) begin
			inf_hdr_q[fc_init.fc_type] <= (fc_init.hdr == link_err_pkg::HDR_INFINITE);
			inf_data_q[fc_init.fc_type] <= (fc_init.data == link_err_pkg::DATA_INFINITE);
		end
	end

	always_comb begin
		init_bad = fc_init.valid && (
			(fc_init.hdr != link_err_pkg::HDR_INFINITE &&
				fc_init.hdr < link_err_pkg::HDR_INIT_MIN) ||
			(fc_init.data != link_err_pkg::DATA_INFINITE &&
				fc_init.data < link_err_pkg::DATA_INIT_MIN) ||
			fc_init.hdr > link_err_pkg::HDR_MAX ||
			fc_init.data > link_err_pkg::DATA_MAX);
		update_bad = fc_update.valid && (
			fc_update.hdr > link_err_pkg::HDR_MAX ||
			fc_update.data > link_err_pkg::DATA_MAX ||
			(inf_hdr_q[fc_update.fc_type] && fc_update.hdr != link_err_pkg::HDR_INFINITE) ||
			(inf_data_q[fc_update.fc_type] &&
				fc_update.data != link_err_pkg::DATA_INFINITE));
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			fc_err_q <= 1'b0;
		end else begin
			fc_err_q <= init_bad || update_bad;
		end
	end

	fc_infinite_a: assert property (@(posedge mclk) disable iff (!arst_n)
		fc_update.valid && inf_data_q[fc_update.fc_type] &&
		fc_update.data != link_err_pkg::DATA_INFINITE |=> fc_err_q)
		else $error("nonzero update after infinite credit not flagged");

endmodule

// >>> hw/link_err_reporter.sv
// link and flow control error detection, status and message reporting
//
// Decided for this implementation: the plain strobed port and the placing of the registers.
module link_err_reporter (
	// clock and reset
	input wire logic mclk,
	input wire logic arst_n,
	// register port
	input wire logic [link_err_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata_q,
	// receive buffer
	input wire logic rx_hdr_overflow,
	input wire logic rx_data_overflow,
	// flow control advertisements
	input wire link_err_pkg::fc_adv_t fc_init,
	input wire link_err_pkg::fc_adv_t fc_update,
	// ack/nak
	input wire logic ack_valid,
	input wire logic [link_err_pkg::SEQ_W-1:0] ack_seq,
	input wire logic [link_err_pkg::SEQ_W-1:0] ackd_seq,
	input wire logic [link_err_pkg::SEQ_W-1:0] next_tx_seq,
	// received tlp end
	input wire logic tlp_end_valid,
	input wire logic tlp_edb,
	input wire logic lcrc_ok,
	input wire logic lcrc_inv_ok,
	input wire logic tlp_invalid,
	// received dllp
	input wire logic dllp_valid,
	input wire logic dllp_crc_ok,
	// replay
	input wire logic replay_rollover,
	input wire logic replay_timeout,
	// reporting
	output link_err_pkg::msg_t err_msg_q,
	output logic irq_q
);

	////////////////////////////////////////////////////////////////////////
	// functions

	// true when ack lies in ackd_seq .. next_tx_seq-1, modulo the sequence space
	function automatic logic seq_outstanding(input logic [11:0] ack, input logic [11:0] ackd,
		input logic [11:0] next);
		logic [11:0] off;
		logic [11:0] span;
		off = ack - ackd;
		span = next - 12'h001 - ackd;
		return off <= span;
	endfunction

	function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] r);
		return a == r;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// declarations
	logic fc_err_q;
	logic [link_err_pkg::NUM_ERR-1:0] ev;
	logic [link_err_pkg::NUM_ERR-1:0] err_status_q;
	logic [link_err_pkg::NUM_ERR-1:0] irq_mask_q;
	logic [link_err_pkg::NUM_ERR-1:0] severity_q;
	logic [link_err_pkg::NUM_ERR-1:0] msg_mask_q;
	logic [link_err_pkg::CTL_W-1:0] control_q;
	logic [link_err_pkg::DEV_W-1:0] dev_status_q;
	logic [link_err_pkg::NUM_ERR-1:0] unc_ev;
	logic [link_err_pkg::NUM_ERR-1:0] cor_ev;
	logic fatal_hit;
	logic nonfatal_hit;
	logic cor_hit;
	logic send_fatal;
	logic send_nonfatal;
	logic send_cor;
	logic rd_err;
	logic rd_dev;

	fc_credit_check u_fc (
		.mclk(mclk),
		.arst_n(arst_n),
		.fc_init(fc_init),
		.fc_update(fc_update),
		.fc_err_q(fc_err_q)
	);

	////////////////////////////////////////////////////////////////////////
	// error detection
	always_comb begin
		ev = '0;
		ev[link_err_pkg::ERR_RX_OVERFLOW] = rx_hdr_overflow || rx_data_overflow;
		ev[link_err_pkg::ERR_FC_PROTOCOL] = fc_err_q;
		ev[link_err_pkg::ERR_LINK_PROTOCOL] = ack_valid &&
			!seq_outstanding(ack_seq, ackd_seq, next_tx_seq);
		ev[link_err_pkg::ERR_BAD_TLP] = tlp_end_valid && (
			(tlp_edb && !lcrc_inv_ok) ||
			(!tlp_edb && !lcrc_ok) ||
			(!tlp_edb && lcrc_ok && tlp_invalid));
		ev[link_err_pkg::ERR_BAD_DLLP] = dllp_valid && !dllp_crc_ok;
		ev[link_err_pkg::ERR_REPLAY_ROLLOVER] = replay_rollover;
		ev[link_err_pkg::ERR_REPLAY_TIMEOUT] = replay_timeout;
	end

	////////////////////////////////////////////////////////////////////////
	// severity and message selection
	always_comb begin
		unc_ev = ev & {{(link_err_pkg::NUM_ERR-link_err_pkg::NUM_UNC){1'b0}},
			{link_err_pkg::NUM_UNC{1'b1}}};
		cor_ev = ev & ~unc_ev;
		fatal_hit = |(unc_ev & severity_q);
		nonfatal_hit = |(unc_ev & ~severity_q);
		cor_hit = |cor_ev;
		send_fatal = |(unc_ev & severity_q & ~msg_mask_q) &&
			control_q[link_err_pkg::CTL_FATAL_REPORT_EN];
		send_nonfatal = |(unc_ev & ~severity_q & ~msg_mask_q) &&
			control_q[link_err_pkg::CTL_NONFATAL_REPORT_EN];
		send_cor = |(cor_ev & ~msg_mask_q) &&
			control_q[link_err_pkg::CTL_COR_REPORT_EN];
		rd_err = reg_rd && reg_hit(reg_addr, link_err_pkg::REG_ERR_STATUS);
		rd_dev = reg_rd && reg_hit(reg_addr, link_err_pkg::REG_DEV_STATUS);
	end

	// one message per cycle; the most severe wins when several coincide
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			err_msg_q <= '{valid: 1'b0, kind: link_err_pkg::MSG_COR};
		end else if (send_fatal) begin
			err_msg_q <= '{valid: 1'b1, kind: link_err_pkg::MSG_FATAL};
		end else if (send_nonfatal) begin
			err_msg_q <= '{valid: 1'b1, kind: link_err_pkg::MSG_NONFATAL};
		end else if (send_cor) begin
			err_msg_q <= '{valid: 1'b1, kind: link_err_pkg::MSG_COR};
		end else begin
			err_msg_q <= '{valid: 1'b0, kind: link_err_pkg::MSG_COR};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// sticky status, cleared by a read; a new event in the read cycle survives
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			err_status_q <= link_err_pkg::ERR_RESET;
		end else if (rd_err) begin
			err_status_q <= ev;
		end else begin
			err_status_q <= err_status_q | ev;
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			dev_status_q <= link_err_pkg::DEV_RESET;
		end else begin
			dev_status_q <= (rd_dev ? '0 : dev_status_q) | {
				(send_fatal || send_nonfatal) &&
					control_q[link_err_pkg::CTL_SYSTEM_ERROR_EN],
				fatal_hit,
				nonfatal_hit,
				cor_hit};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// software-written configuration
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			irq_mask_q <= link_err_pkg::IRQ_MASK_RESET;
			severity_q <= link_err_pkg::SEVERITY_RESET;
			msg_mask_q <= link_err_pkg::MSG_MASK_RESET;
			control_q <= link_err_pkg::CONTROL_RESET;
		end else if (reg_wr) begin
			if (reg_hit(reg_addr, link_err_pkg::REG_IRQ_MASK)) begin
				irq_mask_q <= reg_wdata[link_err_pkg::NUM_ERR-1:0];
			end
			if (reg_hit(reg_addr, link_err_pkg::REG_SEVERITY)) begin
				severity_q <= reg_wdata[link_err_pkg::NUM_ERR-1:0] &
					{{(link_err_pkg::NUM_ERR-link_err_pkg::NUM_UNC){1'b0}},
					{link_err_pkg::NUM_UNC{1'b1}}};
			end
			if (reg_hit(reg_addr, link_err_pkg::REG_MSG_MASK)) begin
				msg_mask_q <= reg_wdata[link_err_pkg::NUM_ERR-1:0];
			end
			if (reg_hit(reg_addr, link_err_pkg::REG_CONTROL)) begin
				control_q <= reg_wdata[link_err_pkg::CTL_W-1:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read data, one cycle after the read strobe, zero otherwise
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			reg_rdata_q <= '0;
		end else if (reg_rd) begin
			case (reg_addr)
				link_err_pkg::REG_ERR_STATUS: begin
					reg_rdata_q <= {25'h0000000, err_status_q};
				end
				link_err_pkg::REG_IRQ_MASK: begin
					reg_rdata_q <= {25'h0000000, irq_mask_q};
				end
				link_err_pkg::REG_SEVERITY: begin
					reg_rdata_q <= {25'h0000000, severity_q};
				end
				link_err_pkg::REG_MSG_MASK: begin
					reg_rdata_q <= {25'h0000000, msg_mask_q};
				end
				link_err_pkg::REG_CONTROL: begin
					reg_rdata_q <= {28'h0000000, control_q};
				end
				link_err_pkg::REG_DEV_STATUS: begin
					reg_rdata_q <= {28'h0000000, dev_status_q};
				end
				default: begin
					reg_rdata_q <= '0;
				end
			endcase
		end else begin
			reg_rdata_q <= '0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// interrupt, level while any status bit whose irq mask bit is set is itself set
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(err_status_q & irq_mask_q);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	rx_overflow_set_a: assert property (@(posedge mclk) disable iff (!arst_n)
		rx_hdr_overflow || rx_data_overflow |=>
			err_status_q[link_err_pkg::ERR_RX_OVERFLOW] &&
			(dev_status_q[link_err_pkg::DEV_FATAL_DETECTED] ||
			dev_status_q[link_err_pkg::DEV_NONFATAL_DETECTED]))
		else $error("receive overflow not recorded");

	init_credit_low_a: assert property (@(posedge mclk) disable iff (!arst_n)
		fc_init.valid && fc_init.data != link_err_pkg::DATA_INFINITE &&
		fc_init.data < link_err_pkg::DATA_INIT_MIN |-> ##2
			err_status_q[link_err_pkg::ERR_FC_PROTOCOL])
		else $error("low initial credit not flagged");

	credit_limit_a: assert property (@(posedge mclk) disable iff (!arst_n)
		fc_update.valid && fc_update.data > link_err_pkg::DATA_MAX |-> ##2
			err_status_q[link_err_pkg::ERR_FC_PROTOCOL])
		else $error("excess data credit not flagged");

	ack_seq_check_a: assert property (@(posedge mclk) disable iff (!arst_n)
		ack_valid && !seq_outstanding(ack_seq, ackd_seq, next_tx_seq) |=>
			err_status_q[link_err_pkg::ERR_LINK_PROTOCOL])
		else $error("bad ack sequence not flagged");

	edb_tlp_bad_a: assert property (@(posedge mclk) disable iff (!arst_n)
		tlp_end_valid && tlp_edb && !lcrc_inv_ok |=>
			err_status_q[link_err_pkg::ERR_BAD_TLP] &&
			dev_status_q[link_err_pkg::DEV_COR_DETECTED])
		else $error("nullified tlp with bad lcrc not flagged");

	end_lcrc_bad_a: assert property (@(posedge mclk) disable iff (!arst_n)
		tlp_end_valid && !tlp_edb && !lcrc_ok |=> err_status_q[link_err_pkg::ERR_BAD_TLP])
		else $error("lcrc failure not flagged");

	end_invalid_tlp_a: assert property (@(posedge mclk) disable iff (!arst_n)
		tlp_end_valid && !tlp_edb && lcrc_ok && tlp_invalid |=>
			err_status_q[link_err_pkg::ERR_BAD_TLP])
		else $error("invalid tlp not flagged");

	dllp_crc_bad_a: assert property (@(posedge mclk) disable iff (!arst_n)
		dllp_valid && !dllp_crc_ok |=> err_status_q[link_err_pkg::ERR_BAD_DLLP] &&
			dev_status_q[link_err_pkg::DEV_COR_DETECTED])
		else $error("dllp crc failure not flagged");

	replay_rollover_a: assert property (@(posedge mclk) disable iff (!arst_n)
		replay_rollover |=> err_status_q[link_err_pkg::ERR_REPLAY_ROLLOVER] &&
			dev_status_q[link_err_pkg::DEV_COR_DETECTED])
		else $error("replay rollover not recorded");

	replay_timeout_a: assert property (@(posedge mclk) disable iff (!arst_n)
		replay_timeout |=> err_status_q[link_err_pkg::ERR_REPLAY_TIMEOUT] &&
			dev_status_q[link_err_pkg::DEV_COR_DETECTED])
		else $error("replay timeout not recorded");

	system_error_a: assert property (@(posedge mclk) disable iff (!arst_n)
		$rose(dev_status_q[link_err_pkg::DEV_SIGNALLED_SERR]) |->
			err_msg_q.valid && err_msg_q.kind != link_err_pkg::MSG_COR &&
			$past(control_q[link_err_pkg::CTL_SYSTEM_ERROR_EN]))
		else $error("system error without uncorrectable message");

	masked_no_msg_a: assert property (@(posedge mclk) disable iff (!arst_n)
		(ev & ~msg_mask_q) == '0 |=> !err_msg_q.valid)
		else $error("message sent for masked error");

	cor_msg_sent_a: assert property (@(posedge mclk) disable iff (!arst_n)
		cor_hit && (cor_ev & ~msg_mask_q) != '0 && unc_ev == '0 &&
		control_q[link_err_pkg::CTL_COR_REPORT_EN] |=>
			err_msg_q.valid && err_msg_q.kind == link_err_pkg::MSG_COR)
		else $error("correctable message missing");

endmodule

// >>> sim/link_partner_model.sv
// link partner model: sends initial and update credit advertisements
module link_partner_model (
	// clock
	input wire logic mclk,
	// advertisements towards the reporter
	output link_err_pkg::fc_adv_t fc_init,
	output link_err_pkg::fc_adv_t fc_update
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		fc_init = '0;
		fc_update = '0;
	end

	// one-cycle advertisement; fields go to a changed pattern once released
	task adv(input logic init, input logic [1:0] t, input logic [7:0] h, input logic [11:0] d);
		link_err_pkg::fc_adv_t a;
		a = {1'b1, t, h, d};
		@(posedge mclk);
		if (init) fc_init <= a;
		else fc_update <= a;
		@(posedge mclk);
		a = ~a;
		a.valid = 1'b0;
		if (init) fc_init <= a;
		else fc_update <= a;
	endtask
endmodule

// >>> sim/link_err_reporter_tb.sv
// self-checking bench for the link error reporter
module link_err_reporter_tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic mclk, arst_n, reg_wr, reg_rd;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata_q, d;
	logic rx_hdr_overflow, rx_data_overflow, ack_valid, tlp_end_valid, tlp_edb;
	logic lcrc_ok, lcrc_inv_ok, tlp_invalid, dllp_valid, dllp_crc_ok;
	logic replay_rollover, replay_timeout, irq_q;
	logic [11:0] ack_seq, ackd_seq, next_tx_seq;
	link_err_pkg::fc_adv_t fc_init, fc_update;
	link_err_pkg::msg_t err_msg_q;
	logic [1:0] last_kind;
	logic [6:0] sev, mmask, imask;
	logic [3:0] ctl;
	int errors, checks_done, msg_cnt, cyc, seed, k;
	int ebit_tab[15] = '{0, 0, 1, 1, 2, 3, 3, 3, 4, 5, 6, -1, -1, -1, 1};

	link_err_reporter u_link_err_reporter (.mclk(mclk), .arst_n(arst_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata_q(reg_rdata_q), .rx_hdr_overflow(rx_hdr_overflow),
		.rx_data_overflow(rx_data_overflow), .fc_init(fc_init), .fc_update(fc_update),
		.ack_valid(ack_valid), .ack_seq(ack_seq), .ackd_seq(ackd_seq),
		.next_tx_seq(next_tx_seq), .tlp_end_valid(tlp_end_valid), .tlp_edb(tlp_edb),
		.lcrc_ok(lcrc_ok), .lcrc_inv_ok(lcrc_inv_ok), .tlp_invalid(tlp_invalid),
		.dllp_valid(dllp_valid), .dllp_crc_ok(dllp_crc_ok),
		.replay_rollover(replay_rollover), .replay_timeout(replay_timeout),
		.err_msg_q(err_msg_q), .irq_q(irq_q));

	link_partner_model u_link_partner_model (.mclk(mclk), .fc_init(fc_init),
		.fc_update(fc_update));

	////////////////////////////////////////////////////////////////////////
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	always @(posedge mclk) begin
		if (err_msg_q.valid === 1'b1) begin
			msg_cnt++;
			last_kind = err_msg_q.kind;
		end
		cyc++;
		if (cyc == 8000) begin
			errors++;
			wrap_up();
		end
	end

	task wrap_up();
		$display("checks_done=%0d errors=%0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	////////////////////////////////////////////////////////////////////////
	task wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask

	task rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata_q;
	endtask

	task quiet();
		rx_hdr_overflow <= 1'b0;
		rx_data_overflow <= 1'b0;
		ack_valid <= 1'b0;
		tlp_end_valid <= 1'b0;
		tlp_edb <= 1'b0;
		lcrc_ok <= 1'b1;
		lcrc_inv_ok <= 1'b0;
		tlp_invalid <= 1'b0;
		dllp_valid <= 1'b0;
		dllp_crc_ok <= 1'b1;
		replay_rollover <= 1'b0;
		replay_timeout <= 1'b0;
	endtask

	// kinds 11..13 are clean traffic at the edge of what is legal
	task fire(input int kind);
		if (kind == 2) u_link_partner_model.adv(1'b0, 2'h0, 8'h80, 12'h800);
		else if (kind == 3) begin
			u_link_partner_model.adv(1'b1, 2'h1, 8'h00, 12'h000);
			u_link_partner_model.adv(1'b0, 2'h1, 8'h03, 12'h005);
		end else if (kind == 13) u_link_partner_model.adv(1'b1, 2'h2, 8'h7f, 12'h7ff);
		else if (kind == 14) u_link_partner_model.adv(1'b1, 2'h3, 8'h01, 12'h007);
		else begin
			@(posedge mclk);
			case (kind)
				0: rx_hdr_overflow <= 1'b1;
				1: rx_data_overflow <= 1'b1;
				4: begin ack_valid <= 1'b1; ack_seq <= 12'h01e; end
				5: begin tlp_end_valid <= 1'b1; tlp_edb <= 1'b1; end
				6: begin tlp_end_valid <= 1'b1; lcrc_ok <= 1'b0; end
				7: begin tlp_end_valid <= 1'b1; tlp_invalid <= 1'b1; end
				8: begin dllp_valid <= 1'b1; dllp_crc_ok <= 1'b0; end
				9: replay_rollover <= 1'b1;
				10: replay_timeout <= 1'b1;
				11: tlp_end_valid <= 1'b1;
				default: begin ack_valid <= 1'b1; ack_seq <= 12'h013; end
			endcase
			@(posedge mclk);
			quiet();
		end
	endtask

	task check_event(input int kind);
		int b, n0;
		logic send, fatal;
		logic [31:0] dev;
		b = ebit_tab[kind];
		n0 = msg_cnt;
		fire(kind);
		repeat (4) @(posedge mclk);
		#1;
		fatal = b >= 0 && b < 3 && sev[b];
		send = b >= 0 && !mmask[b] && (b >= 3 ? ctl[0] : (fatal ? ctl[2] : ctl[1]));
		chk("msg count", 32'(send), 32'(msg_cnt - n0));
		if (send) chk("msg kind", b >= 3 ? 32'h0 : (fatal ? 32'h2 : 32'h1), 32'(last_kind));
		chk("irq set", 32'(b >= 0 && imask[b]), 32'(irq_q));
		rd(link_err_pkg::REG_ERR_STATUS, d);
		chk("err status", b >= 0 ? 32'h1 << b : 32'h0, d);
		dev = b < 0 ? 32'h0 : (b >= 3 ? 32'h1 : (fatal ? 32'h4 : 32'h2));
		if (b >= 0 && b < 3 && send && ctl[3]) dev = dev | 32'h8;
		rd(link_err_pkg::REG_DEV_STATUS, d);
		chk("dev status", dev, d);
		chk("irq clear", 32'h0, 32'(irq_q));
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		seed = 59;
		arst_n = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		ack_seq = 12'h000;
		ackd_seq = 12'h00a;
		next_tx_seq = 12'h014;
		quiet();
		repeat (3) @(posedge mclk);
		arst_n <= 1'b1;
		rd(link_err_pkg::REG_SEVERITY, d);
		chk("severity reset", 32'h01, d);
		rd(link_err_pkg::REG_CONTROL, d);
		chk("control reset", 32'h0, d);
		rd(link_err_pkg::REG_IRQ_MASK, d);
		chk("irq mask reset", 32'h0, d);
		wr(8'h20, 32'hffffffff);
		rd(8'h20, d);
		chk("unmapped", 32'h0, d);
		wr(link_err_pkg::REG_SEVERITY, 32'h7f);
		rd(link_err_pkg::REG_SEVERITY, d);
		chk("severity bits", 32'h07, d);
		sev = 7'h01;
		wr(link_err_pkg::REG_SEVERITY, 32'(sev));
		ctl = 4'hf;
		wr(link_err_pkg::REG_CONTROL, 32'(ctl));
		imask = 7'h7f;
		wr(link_err_pkg::REG_IRQ_MASK, 32'(imask));
		mmask = 7'h00;
		for (k = 0; k < 15; k++) check_event(k);
		mmask = 7'h10;
		wr(link_err_pkg::REG_MSG_MASK, 32'(mmask));
		check_event(8);
		mmask = 7'h00;
		wr(link_err_pkg::REG_MSG_MASK, 32'(mmask));
		ctl = 4'h7;
		wr(link_err_pkg::REG_CONTROL, 32'(ctl));
		check_event(0);
		ctl = 4'hd;
		wr(link_err_pkg::REG_CONTROL, 32'(ctl));
		check_event(4);
		imask = 7'h00;
		wr(link_err_pkg::REG_IRQ_MASK, 32'(imask));
		check_event(10);
		for (int i = 0; i < 40; i++) begin
			sev = 7'($unsigned($random(seed)) % 8);
			ctl = 4'($random(seed));
			imask = 7'($random(seed));
			wr(link_err_pkg::REG_SEVERITY, 32'(sev));
			wr(link_err_pkg::REG_CONTROL, 32'(ctl));
			wr(link_err_pkg::REG_IRQ_MASK, 32'(imask));
			check_event($unsigned($random(seed)) % 15);
		end
		wrap_up();
	end
endmodule
